// ---- rtl/cache_sram_pkg.sv ----
// Package with constants, types and carriers for the synchronous burst cache memory.
package cache_sram_pkg;

  // ==========================================================================
  // Geometry
  // ==========================================================================
  localparam int ADDR_W = 16;
  localparam int DEPTH  = 65536;
  localparam int LANES  = 2;
  localparam int BYTE_W = 8;
  localparam int BEAT_W = 2;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_PS = 8000;
  localparam int ACCESS_MAX_PS = 8500;
  // A longest time rounds down, but never below one cycle.
  localparam int ACCESS_CYCLES = (ACCESS_MAX_PS / CLK_PERIOD_PS) < 1 ? 1 : (ACCESS_MAX_PS / CLK_PERIOD_PS);

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [ADDR_W-BEAT_W-1:0] RST_UPPER = 14'h0000;
  localparam logic [BEAT_W-1:0]        RST_BASE  = 2'h0;
  localparam logic [BEAT_W-1:0]        RST_BEAT  = 2'h0;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic
  {
    ORDER_INTERLEAVED = 1'b0,
    ORDER_LINEAR      = 1'b1
  } burst_order_t;

  typedef enum logic [1:0]
  {
    PH_IDLE    = 2'b00,
    PH_READ    = 2'b01,
    PH_PROC_WR = 2'b10,
    PH_WRITE   = 2'b11
  } phase_t;

  // One byte lane: eight data bits and their parity bit.
  typedef struct packed
  {
    logic              par;
    logic [BYTE_W-1:0] data;
  } lane_t;

  typedef lane_t [LANES-1:0] word_t;

  // Strobes and selects, all active low as on the pins.
  typedef struct packed
  {
    logic cs_n;
    logic processor_address_strobe_n;
    logic controller_address_strobe_n;
    logic burst_step_n;
  } ctl_t;

endpackage : cache_sram_pkg

// ---- rtl/sync_burst_cache_sram.sv ----
// Synchronous 64K x 18 burst cache memory with common data and parity lines.
`timescale 1ns/1ps
`default_nettype none

module sync_burst_cache_sram
#(
  parameter int                           ADDR_BITS = cache_sram_pkg::ADDR_W,
  parameter cache_sram_pkg::burst_order_t ORDER     = cache_sram_pkg::ORDER_INTERLEAVED
)
(
  // Clock and reset
  input  wire logic                                sys_clk,
  input  wire logic                                arst_n,
  // Address and access control
  input  wire logic [ADDR_BITS-1:0]                addr,
  input  wire cache_sram_pkg::ctl_t                ctl,
  input  wire logic                                upper_byte_write_n,
  input  wire logic                                lower_byte_write_n,
  input  wire logic                                oe_n,
  // Data lines, split into input, output and per-lane enable
  input  wire logic [cache_sram_pkg::LANES*cache_sram_pkg::BYTE_W-1:0] dq_in,
  output logic      [cache_sram_pkg::LANES*cache_sram_pkg::BYTE_W-1:0] dq_out,
  output logic      [cache_sram_pkg::LANES-1:0]                        dq_oe,
  // Parity lines, one per lane
  input  wire logic [cache_sram_pkg::LANES-1:0]    parity_lines_in,
  output logic      [cache_sram_pkg::LANES-1:0]    parity_lines_out,
  output logic      [cache_sram_pkg::LANES-1:0]    parity_lines_oe
);
  import cache_sram_pkg::*;

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  // The address registers and the depth of the array are fixed to this width.
  if (ADDR_BITS != ADDR_W)
  begin : g_bad_width
    $error("sync_burst_cache_sram: ADDR_BITS must be 16");
  end

  // ==========================================================================
  // Burst order
  // ==========================================================================
  function automatic logic [BEAT_W-1:0] beat_low(input logic [BEAT_W-1:0] base,
                                                 input logic [BEAT_W-1:0] beat);
    if (ORDER == ORDER_LINEAR)
      beat_low = BEAT_W'(base + beat);
    else
      beat_low = base ^ beat;
  endfunction : beat_low

  // ==========================================================================
  // State
  // ==========================================================================
  logic [LANES*(BYTE_W+1)-1:0] mem [DEPTH];
  logic [ADDR_W-BEAT_W-1:0]    upper_r;
  logic [ADDR_W-BEAT_W-1:0]    upper_nxt;
  logic [BEAT_W-1:0]           base_r;
  logic [BEAT_W-1:0]           base_nxt;
  logic [BEAT_W-1:0]           beat_r;
  logic [BEAT_W-1:0]           beat_nxt;
  phase_t                      phase_r;
  phase_t                      phase_nxt;
  word_t                       rd_word_r;
  word_t                       rd_word_nxt;

  // ==========================================================================
  // Decode of the sampled controls
  // ==========================================================================
  wire logic              selected;
  wire logic              proc_start;
  wire logic              ctrl_start;
  wire logic              start;
  wire logic              deselect;
  wire logic              advance;
  wire logic [LANES-1:0]  wr_req;
  wire logic              wr_any;
  wire logic              burst_live;
  wire logic [LANES-1:0]  wr_lane;
  wire logic [ADDR_W-1:0] eff_addr;
  wire word_t             wr_word;
  wire word_t             mem_word;

  assign selected   = ~ctl.cs_n;
  assign proc_start = selected & ~ctl.processor_address_strobe_n;
  // The controller strobe counts only when the processor strobe is high.
  assign ctrl_start = selected & ~ctl.controller_address_strobe_n
                    & ctl.processor_address_strobe_n;
  assign start      = proc_start | ctrl_start;
  assign deselect   = ctl.cs_n & ~(ctl.processor_address_strobe_n
                    & ctl.controller_address_strobe_n);
  assign advance    = ~start & ~ctl.burst_step_n & (phase_r != PH_IDLE);
  assign wr_req     = {~upper_byte_write_n, ~lower_byte_write_n};
  assign wr_any     = |wr_req;
  assign burst_live = ~start & ~deselect & (phase_r != PH_IDLE);

  // Writes on the processor-strobe start edge are dropped; the host uses
  // that cycle for its tag check and commits on the following edge.
  assign wr_lane    = proc_start ? '0 :
                      ctrl_start ? wr_req :
                      burst_live ? wr_req : '0;

  assign upper_nxt  = start ? addr[ADDR_W-1:BEAT_W] : upper_r;
  assign base_nxt   = start ? addr[BEAT_W-1:0] : base_r;
  assign beat_nxt   = start ? RST_BEAT :
                      advance ? BEAT_W'(beat_r + 2'h1) : beat_r;
  assign eff_addr   = {upper_nxt, beat_low(base_nxt, beat_nxt)};

  assign wr_word    = {lane_t'{parity_lines_in[1], dq_in[15:8]},
                       lane_t'{parity_lines_in[0], dq_in[7:0]}};
  assign mem_word   = word_t'(mem[eff_addr]);

  // ==========================================================================
  // Phase of the access
  // ==========================================================================
  always_comb
  begin
    phase_nxt = phase_r;
    if (proc_start)
      phase_nxt = PH_PROC_WR;
    else if (ctrl_start)
      phase_nxt = wr_any ? PH_WRITE : PH_READ;
    else if (deselect)
      phase_nxt = PH_IDLE;
    else
    begin
      unique case (phase_r)
        PH_IDLE:    phase_nxt = PH_IDLE;
        PH_READ:    phase_nxt = wr_any ? PH_WRITE : PH_READ;
        PH_PROC_WR: phase_nxt = wr_any ? PH_WRITE : PH_READ;
        PH_WRITE:   phase_nxt = wr_any ? PH_WRITE : PH_READ;
      endcase
    end
  end

  // ==========================================================================
  // Read data register
  // ==========================================================================
  // The register carries what the addressed word holds after this edge, so a
  // written lane reads back its new value without an extra cycle.
  generate
    for (genvar l = 0; l < LANES; l++)
    begin : g_lane
      assign rd_word_nxt[l] = wr_lane[l] ? wr_word[l] : mem_word[l];
    end
  endgenerate

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      upper_r   <= RST_UPPER;
      base_r    <= RST_BASE;
      beat_r    <= RST_BEAT;
      phase_r   <= PH_IDLE;
      rd_word_r <= '0;
    end
    else
    begin
      upper_r   <= upper_nxt;
      base_r    <= base_nxt;
      beat_r    <= beat_nxt;
      phase_r   <= phase_nxt;
      rd_word_r <= rd_word_nxt;
    end
  end

  // The array has no reset; its contents are undefined until written.
  always_ff @(posedge sys_clk)
  begin
    for (int l = 0; l < LANES; l++)
    begin
      if (wr_lane[l])
        mem[eff_addr][l*(BYTE_W+1) +: (BYTE_W+1)] <= wr_word[l];
    end
  end

  // ==========================================================================
  // Pin drivers
  // ==========================================================================
  // The enables are the one exception to registered outputs: output enable
  // and the byte writes must float the lanes without waiting for an edge,
  // which protects against contention when the host turns the bus round.
  wire logic drive_phase;

  assign drive_phase = (phase_r == PH_READ) | (phase_r == PH_PROC_WR);

  always_comb
  begin
    for (int l = 0; l < LANES; l++)
    begin
      dq_oe[l]           = drive_phase & ~oe_n & ~wr_req[l];
      parity_lines_oe[l] = drive_phase & ~oe_n & ~wr_req[l];
    end
  end

  assign dq_out           = {rd_word_r[1].data, rd_word_r[0].data};
  assign parity_lines_out = {rd_word_r[1].par, rd_word_r[0].par};

endmodule : sync_burst_cache_sram

`default_nettype wire

// ---- tb/host_side.sv ----
// Host model: its half of the shared data and parity lines.
`timescale 1ns/1ps
`default_nettype none
module host_side
(
  input  wire logic        sys_clk,
  input  wire logic        oe_n,
  input  wire logic        drv,
  input  wire logic [17:0] host_word,
  input  wire logic [15:0] dev_dq,
  input  wire logic [1:0]  dev_par,
  input  wire logic [1:0]  dev_dq_oe,
  input  wire logic [1:0]  dev_par_oe,
  output logic      [15:0] line_dq,
  output logic      [1:0]  line_par
);
  // Floating lines show the inverse of the host word, so a lane that nobody drives never matches by chance.
  wire host_on = drv && oe_n;
  assign line_dq[7:0] = dev_dq_oe[0] ? dev_dq[7:0] : host_on ? host_word[7:0] : ~host_word[7:0];
  assign line_dq[15:8] = dev_dq_oe[1] ? dev_dq[15:8] : host_on ? host_word[16:9] : ~host_word[16:9];
  assign line_par[0] = dev_par_oe[0] ? dev_par[0] : host_on ? host_word[8] : ~host_word[8];
  assign line_par[1] = dev_par_oe[1] ? dev_par[1] : host_on ? host_word[17] : ~host_word[17];
endmodule : host_side
`default_nettype wire

// ---- tb/sram_checker.sv ----
// Port checker for the burst cache memory.
`timescale 1ns/1ps
`default_nettype none
module sram_checker
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Controls
  input wire cache_sram_pkg::ctl_t ctl,
  input wire logic upper_byte_write_n,
  input wire logic lower_byte_write_n,
  input wire logic oe_n,
  // Lines
  input wire logic [15:0] dq_in,
  input wire logic [15:0] dq_out,
  input wire logic [1:0]  dq_oe,
  input wire logic [1:0]  parity_lines_in,
  input wire logic [1:0]  parity_lines_out,
  input wire logic [1:0]  parity_lines_oe
);
  import cache_sram_pkg::*;
  // ==========================================================================
  // Decodes
  // ==========================================================================
  wire st = !ctl.processor_address_strobe_n || !ctl.controller_address_strobe_n;
  wire wn = upper_byte_write_n && lower_byte_write_n;
  wire wz = !upper_byte_write_n && !lower_byte_write_n;
  wire rd = !ctl.cs_n && st && wn;
  wire cw = !ctl.cs_n && ctl.processor_address_strobe_n && !ctl.controller_address_strobe_n && wz;
  wire pw = !ctl.cs_n && !ctl.processor_address_strobe_n;
  wire qt = !ctl.cs_n && !st && ctl.burst_step_n;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_lower_lane_float: assert property (!lower_byte_write_n |-> !dq_oe[0] && !parity_lines_oe[0])
    else $error("lane 0 driven in write");
  a_upper_lane_float: assert property (!upper_byte_write_n |-> !dq_oe[1] && !parity_lines_oe[1])
    else $error("lane 1 driven in write");
  a_oe_gates_drive: assert property (oe_n |-> dq_oe == 2'h0 && parity_lines_oe == 2'h0)
    else $error("driven with enable off");
  a_deselect_no_drive: assert property (ctl.cs_n && st |=> dq_oe == 2'h0)
    else $error("deselected start drives");
  a_read_drives: assert property (rd |=> oe_n || dq_oe == {upper_byte_write_n, lower_byte_write_n})
    else $error("read not driven");
  a_ctrl_write_once: assert property (cw |=> dq_out == $past(dq_in)
    && parity_lines_out == $past(parity_lines_in))
    else $error("single cycle write lost");
  a_proc_write_late: assert property (pw ##1 (qt && wz) |=> dq_out == $past(dq_in))
    else $error("second cycle write lost");
  a_step_holds_beat: assert property (rd ##1 (qt && wn) |=> $stable(dq_out))
    else $error("beat moved without step");
  cover property (cw);
  cover property (pw ##1 !lower_byte_write_n);
  cover property (rd ##1 !ctl.burst_step_n);
endmodule : sram_checker
bind sync_burst_cache_sram sram_checker sram_checker_i (.sys_clk, .arst_n, .ctl, .upper_byte_write_n,
  .lower_byte_write_n, .oe_n, .dq_in, .dq_out, .dq_oe, .parity_lines_in, .parity_lines_out, .parity_lines_oe);
`default_nettype wire

// ---- tb/tb.sv ----
// Bench: both burst orders against one behavioural model.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cache_sram_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  ctl_t ctl = 4'hF;
  logic upper_byte_write_n = 1'b1;
  logic lower_byte_write_n = 1'b1;
  logic oe_req_n = 1'b1;
  logic [17:0] hw = 18'h00000;
  logic hd = 1'b1;
  logic [15:0] dq_out [2];
  logic [1:0] par_out [2];
  int err_total = 0;
  int cmp_count = 0;
  logic [17:0] mem [int];
  int ea [2];
  logic act = 1'b0;
  logic [1:0] base = 2'h0;
  logic [1:0] beat = 2'h0;
  logic [13:0] up = 14'h0000;
  // The host drops output enable whenever it drives write data; a write without host data
  // may keep output enable low, so only the byte writes can float the device's lanes.
  wire logic host_drv = hd && (!upper_byte_write_n || !lower_byte_write_n);
  wire logic oe_n = oe_req_n || host_drv;
  always #4 sys_clk = ~sys_clk;
  for (genvar k = 0; k < 2; k++)
  begin : g_v
    logic [15:0] dq_in;
    logic [1:0] par_in;
    logic [1:0] dq_oe;
    logic [1:0] par_oe;
    host_side host_side_i (.sys_clk, .oe_n, .drv(host_drv), .host_word(hw),
      .dev_dq(dq_out[k]), .dev_par(par_out[k]), .dev_dq_oe(dq_oe), .dev_par_oe(par_oe), .line_dq(dq_in),
      .line_par(par_in));
    sync_burst_cache_sram #(.ORDER(burst_order_t'(k))) sync_burst_cache_sram_i (.sys_clk, .arst_n, .addr, .ctl,
      .upper_byte_write_n, .lower_byte_write_n, .oe_n, .dq_in, .dq_out(dq_out[k]), .dq_oe,
      .parity_lines_in(par_in), .parity_lines_out(par_out[k]), .parity_lines_oe(par_oe));
  end
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // The model reads the inputs the design samples at this edge, then queues the next ones.
  task automatic cyc(input logic [3:0] c, input logic [1:0] w, input logic [15:0] a);
    logic st;
    logic wr;
    logic [17:0] wd;
    @(posedge sys_clk);
    wd = hd ? hw : ~hw;
    st = !ctl.processor_address_strobe_n || !ctl.controller_address_strobe_n;
    wr = !upper_byte_write_n || !lower_byte_write_n;
    if (ctl.cs_n && st)
      act = 1'b0;
    else if (st)
      {act, up, base, beat, wr} = {1'b1, addr, 2'h0, wr && ctl.processor_address_strobe_n};
    else if (act && !ctl.burst_step_n)
      beat++;
    for (int k = 0; k < 2; k++)
    begin
      ea[k] = k * 65536 + {up, k ? 2'(base + beat) : base ^ beat};
      if (act && wr && !lower_byte_write_n)
        mem[ea[k]][8:0] = wd[8:0];
      if (act && wr && !upper_byte_write_n)
        mem[ea[k]][17:9] = wd[17:9];
    end
    ctl <= c;
    {upper_byte_write_n, lower_byte_write_n} <= w;
    addr <= a;
    hw <= 18'($urandom);
    hd <= $urandom_range(3, 0) != 0;
    oe_req_n <= 1'($urandom);
    @(negedge sys_clk);
    for (int k = 0; k < 2; k++)
      if (act && mem.exists(ea[k]))
        check({par_out[k][1], dq_out[k][15:8], par_out[k][0], dq_out[k][7:0]}, mem[ea[k]]);
  endtask : cyc
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    void'($urandom(32'hB97EEBA8));
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
      cyc(4'h5, 2'h0, {i[2] ? 14'h3FFF : 14'h0001, 2'(i)});
    cyc(4'h1, 2'h0, 16'h0006);
    cyc(4'h7, 2'h2, 16'h0000);
    for (int i = 0; i < 600; i++)
      cyc({$urandom_range(7, 0) == 0, $urandom_range(2, 0) != 0, $urandom_range(2, 0) != 0, 1'($urandom)},
        2'($urandom), {$urandom_range(1, 0) ? 14'h3FFF : 14'h0001, 2'($urandom)});
    cyc(4'hF, 2'h3, 16'h0000);
    end_of_test();
  end
  initial
  begin
    #20000;
    err_total++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
